// ==== verilog/swc_consts.svh ====
// constants for the sleep and wake-up controller: offsets, fields, resets
// assumes inclusion by bare name from package and modules alike
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH

// register byte addresses, one aligned word each
`define SWC_CFG_OFF 8'h00
`define SWC_IRQ_EN_OFF 8'h04
`define SWC_STATUS_OFF 8'h08
`define SWC_FLAGS_OFF 8'h0C

// configuration register fields
`define SWC_CFG_WDT_EN 0
`define SWC_CFG_GIE 1
`define SWC_CFG_T1_ASYNC 2
`define SWC_CFG_T3_ASYNC 3
`define SWC_CFG_T1_EXTCLK 4
`define SWC_CFG_SSP_SLAVE 5
`define SWC_CFG_USART_SLAVE 6
`define SWC_CFG_ADC_RC 7
`define SWC_CFG_W 8
`define SWC_CFG_RST 8'h00

// status register fields
`define SWC_ST_PD 0
`define SWC_ST_TO 1
`define SWC_ST_ASLEEP 2
`define SWC_ST_WAKE 3

// wake source indices
`define SWC_SRC_INT_PIN 0
`define SWC_SRC_PORT_CHG 1
`define SWC_SRC_PSP 2
`define SWC_SRC_FIRST_TIMER_IRQ 3
`define SWC_SRC_THIRD_TIMER_IRQ 4
`define SWC_SRC_CAPTURE 5
`define SWC_SRC_SPECIAL 6
`define SWC_SRC_SSP_SS 7
`define SWC_SRC_SSP_XFER 8
`define SWC_SRC_USART 9
`define SWC_SRC_ADC 10
`define SWC_SRC_EEPROM 11
`define SWC_SRC_LVD 12
`define SWC_NSRC 13
`define SWC_IRQ_EN_RST 13'h0000

// instruction encodings
`define SWC_OP_WDT_CLEAR 16'h0004
`define SWC_OP_SOFT_RESET 16'h00FF
`define SWC_OP_SLEEP_DEF 16'h0003

// status reset values: both set at power-up
`define SWC_PD_RST 1'b1
`define SWC_TO_RST 1'b1

// prefetch distance of the sleep instruction
`define SWC_PREFETCH_STEP 2

`endif

// ==== verilog/swc_pkg.sv ====
// types shared by the sleep and wake-up controller modules
// assumes swc_consts.svh on the include path
package swc_pkg;
`include "swc_consts.svh"

    // power state of the core
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP_EXEC = 2'b01,
        ST_ASLEEP = 2'b10,
        ST_WAKE = 2'b11
    } pwr_state_t;

    typedef logic [`SWC_NSRC-1:0] src_vec_t;
    typedef logic [`SWC_CFG_W-1:0] cfg_t;
endpackage

// ==== verilog/swc_if.sv ====
// internal carrier between the controller top and its helpers
// assumes all three ends on one clock
`timescale 1ns/1ps
interface swc_if;
    import swc_pkg::*;
    src_vec_t flags; // raw interrupt flags
    src_vec_t enables; // individual enable bits
    cfg_t cfg; // mode qualifiers
    logic wake_req; // unclocked wake request
    logic [15:0] opcode; // instruction word
    logic op_valid; // instruction issued
    logic sleep_enc_hit; // decoded sleep
    logic wdt_clear_hit; // decoded watchdog clear
    logic soft_reset_hit; // decoded software reset

    modport top (output flags, enables, cfg, opcode, op_valid,
        input wake_req, sleep_enc_hit, wdt_clear_hit, soft_reset_hit);
    modport qual (input flags, enables, cfg, output wake_req);
    modport dec (input opcode, op_valid,
        output sleep_enc_hit, wdt_clear_hit, soft_reset_hit);
endinterface // swc_if

// ==== verilog/wake_qualifier.sv ====
// combinational wake request from qualified interrupt sources
// assumes flags and enables come from logic on the core clock
`timescale 1ns/1ps
module wake_qualifier
    import swc_pkg::*;
(
    // carrier
    swc_if.qual bus
);
    // per-source mode qualifier
    src_vec_t mode_ok;
    // qualified and enabled sources
    src_vec_t armed;

    // only sources that run without on-chip clocks may wake
    always_comb begin
        mode_ok = '0; // clock-dependent sources stay silent
        mode_ok[`SWC_SRC_INT_PIN] = 1'b1;
        mode_ok[`SWC_SRC_PORT_CHG] = 1'b1;
        mode_ok[`SWC_SRC_PSP] = 1'b1;
        mode_ok[`SWC_SRC_CAPTURE] = 1'b1;
        mode_ok[`SWC_SRC_SSP_SS] = 1'b1;
        mode_ok[`SWC_SRC_EEPROM] = 1'b1;
        mode_ok[`SWC_SRC_LVD] = 1'b1;
        // timers only as asynchronous counters
        mode_ok[`SWC_SRC_FIRST_TIMER_IRQ] = bus.cfg[`SWC_CFG_T1_ASYNC];
        mode_ok[`SWC_SRC_THIRD_TIMER_IRQ] = bus.cfg[`SWC_CFG_T3_ASYNC];
        mode_ok[`SWC_SRC_SPECIAL] = bus.cfg[`SWC_CFG_T1_ASYNC]
            & bus.cfg[`SWC_CFG_T1_EXTCLK];
        // serial ports only when clocked from outside
        mode_ok[`SWC_SRC_SSP_XFER] = bus.cfg[`SWC_CFG_SSP_SLAVE];
        mode_ok[`SWC_SRC_USART] = bus.cfg[`SWC_CFG_USART_SLAVE];
        // converter only on its own rc clock
        mode_ok[`SWC_SRC_ADC] = bus.cfg[`SWC_CFG_ADC_RC];
    end

    // flag and enable, global enable deliberately absent
    assign armed = bus.flags & bus.enables & mode_ok;
    assign bus.wake_req = |armed;
endmodule // wake_qualifier

// ==== verilog/op_decoder.sv ====
// decodes the power-related instructions from the sequencer word
// assumes opcode and op_valid from the same clock as the top
`timescale 1ns/1ps
module op_decoder
    import swc_pkg::*;
#(
    parameter logic [15:0] SLEEP_OP = `SWC_OP_SLEEP_DEF
)(
    // carrier
    swc_if.dec bus
);
    // exact match of a full instruction word
    function automatic logic op_is(input logic [15:0] word,
                                   input logic [15:0] code);
        op_is = (word == code);
    endfunction

    assign bus.sleep_enc_hit = bus.op_valid & op_is(bus.opcode, SLEEP_OP);
    assign bus.wdt_clear_hit = bus.op_valid
        & op_is(bus.opcode, `SWC_OP_WDT_CLEAR);
    assign bus.soft_reset_hit = bus.op_valid
        & op_is(bus.opcode, `SWC_OP_SOFT_RESET);
endmodule // op_decoder

// ==== verilog/sleep_wakeup_control.sv ====
// sleep and wake-up controller of an 8-bit core, with ahb-lite registers
// assumes a single ahb-lite master, the sequencer and peripherals on hclk
`timescale 1ns/1ps
module sleep_wakeup_control
    import swc_pkg::*;
#(
    parameter int PC_W = 21,
    parameter logic [15:0] SLEEP_OP = `SWC_OP_SLEEP_DEF
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // instruction sequencer
    input wire logic op_valid,
    input wire logic [15:0] opcode,
    input wire logic [PC_W-1:0] pc,
    output logic [PC_W-1:0] prefetch_addr,
    output logic exec_next,
    output logic vector_branch,
    output logic core_clk_en,
    // watchdog
    input wire logic watchdog_timeout,
    output logic watchdog_clear,
    // pin and peripherals
    input wire logic master_reset_pin_n,
    input wire logic [`SWC_NSRC-1:0] irq_flags,
    // reset and power outputs
    output logic device_reset,
    output logic osc_drv_en,
    output logic io_hold
);
    // refuse a program counter too narrow for the prefetch step
    generate
        if (PC_W < 2) begin : g_pc_check
            $error("program counter width below two bits");
        end
    endgenerate

    // carrier to the helpers
    swc_if link();

    // helper instances
    wake_qualifier u_qual (
        .bus(link.qual)
    );
    op_decoder #(
        .SLEEP_OP(SLEEP_OP)
    ) u_dec (
        .bus(link.dec)
    );

    // software-visible state
    cfg_t cfg_r; // mode qualifiers and enables
    src_vec_t irq_en_r; // individual enables
    logic pd_r; // powerdown_status_bit
    logic to_r; // timeout_status_bit
    pwr_state_t state_r; // power state
    pwr_state_t state_nxt; // next power state
    // pin synchroniser
    logic mrst_meta_r; // first stage, read only by second
    logic mrst_sync_n_r; // synchronised master reset level
    // ahb data phase capture
    logic wr_pend_r; // write data phase pending
    logic [7:0] wr_addr_r; // captured write offset
    // decoded events
    logic wake_now; // any wake event this cycle
    logic wdt_wake; // watchdog time-out that may wake
    logic sleep_go; // sleep that really executes
    logic sleep_nop; // sleep with wake already pending
    logic ext_reset; // master reset seen
    logic soft_rst_pend_r; // software reset to start next phase
    logic ahb_rd; // read address phase accepted
    logic ahb_wr; // write address phase accepted
    logic gie_r; // global enable sampled at wake

    // feed the helpers
    assign link.flags = irq_flags;
    assign link.enables = irq_en_r;
    assign link.cfg = cfg_r;
    assign link.opcode = opcode;
    assign link.op_valid = op_valid;

    // event decode
    assign ext_reset = ~mrst_sync_n_r;
    assign wdt_wake = watchdog_timeout & cfg_r[`SWC_CFG_WDT_EN];
    assign wake_now = link.wake_req | wdt_wake;
    // a pending wake turns sleep into a nop
    assign sleep_nop = link.sleep_enc_hit & link.wake_req;
    assign sleep_go = link.sleep_enc_hit & ~link.wake_req
        & (state_r == ST_RUN);

    // ahb address phase qualifiers
    assign ahb_rd = hsel & hready & htrans[1] & ~hwrite;
    assign ahb_wr = hsel & hready & htrans[1] & hwrite;

    // two-flop synchroniser for the master reset pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mrst_meta_r <= 1'b1;
            mrst_sync_n_r <= 1'b1;
        end else begin
            mrst_meta_r <= master_reset_pin_n;
            mrst_sync_n_r <= mrst_meta_r;
        end
    end

    // power state transitions
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            // running: sleep only when no wake is pending
            ST_RUN: begin
                if (sleep_go) begin
                    state_nxt = ST_SLEEP_EXEC;
                end
            end
            // sleep completes, late interrupt wakes at once
            ST_SLEEP_EXEC: begin
                if (wake_now) begin
                    state_nxt = ST_WAKE;
                end else begin
                    state_nxt = ST_ASLEEP;
                end
            end
            // asleep until a wake source fires
            ST_ASLEEP: begin
                if (wake_now) begin
                    state_nxt = ST_WAKE;
                end
            end
            // resume with the prefetched instruction
            ST_WAKE: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // power state register, master or software reset returns to run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_RUN;
        end else if (ext_reset || soft_rst_pend_r) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // powerdown and timeout status bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_r <= `SWC_PD_RST;
            to_r <= `SWC_TO_RST;
        end else if (link.wdt_clear_hit) begin
            pd_r <= 1'b1;
            to_r <= 1'b1;
        end else if (sleep_go) begin
            pd_r <= 1'b0;
            to_r <= 1'b1;
        end else if (((state_r == ST_ASLEEP) || (state_r == ST_SLEEP_EXEC))
                     && wdt_wake && !link.wake_req) begin
            to_r <= 1'b0;
        end
    end

    // watchdog clear strobe: the clear instruction, or sleep entry with the watchdog enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_clear <= 1'b0;
        end else begin
            watchdog_clear <= link.wdt_clear_hit
                | (sleep_go & cfg_r[`SWC_CFG_WDT_EN]);
        end
    end

    // prefetch address captured when the sleep instruction executes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prefetch_addr <= '0;
        end else if (sleep_go) begin
            prefetch_addr <= pc + PC_W'(`SWC_PREFETCH_STEP);
        end
    end

    // clock, oscillator and port hold while asleep
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_clk_en <= 1'b1;
            osc_drv_en <= 1'b1;
            io_hold <= 1'b0;
        end else if (ext_reset || soft_rst_pend_r) begin
            core_clk_en <= 1'b1;
            osc_drv_en <= 1'b1;
            io_hold <= 1'b0;
        end else begin
            core_clk_en <= (state_nxt == ST_RUN) || (state_nxt == ST_WAKE);
            osc_drv_en <= (state_nxt != ST_ASLEEP);
            io_hold <= (state_nxt == ST_ASLEEP);
        end
    end

    // global enable held at wake for the vector decision
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gie_r <= 1'b0;
        end else if (state_nxt == ST_WAKE) begin
            gie_r <= cfg_r[`SWC_CFG_GIE];
        end
    end

    // resume strobes: next instruction first, then vector if enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exec_next <= 1'b0;
            vector_branch <= 1'b0;
        end else if (ext_reset || soft_rst_pend_r) begin
            exec_next <= 1'b0;
            vector_branch <= 1'b0;
        end else begin
            exec_next <= (state_nxt == ST_WAKE);
            vector_branch <= (state_r == ST_WAKE) && gie_r;
        end
    end

    // software reset starts one phase after decode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_rst_pend_r <= 1'b0;
        end else begin
            soft_rst_pend_r <= link.soft_reset_hit;
        end
    end

    // device reset out: master pin or software reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            device_reset <= 1'b0;
        end else begin
            device_reset <= ext_reset | soft_rst_pend_r;
        end
    end

    // ahb write capture in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (hready) begin
            wr_pend_r <= ahb_wr;
            wr_addr_r <= haddr[7:0];
        end
    end

    // configuration register, reset by master and software reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= `SWC_CFG_RST;
        end else if (ext_reset || soft_rst_pend_r) begin
            cfg_r <= `SWC_CFG_RST;
        end else if (wr_pend_r && wr_addr_r == `SWC_CFG_OFF) begin
            cfg_r <= hwdata[`SWC_CFG_W-1:0];
        end
    end

    // individual enable register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_r <= `SWC_IRQ_EN_RST;
        end else if (ext_reset || soft_rst_pend_r) begin
            irq_en_r <= `SWC_IRQ_EN_RST;
        end else if (wr_pend_r && wr_addr_r == `SWC_IRQ_EN_OFF) begin
            irq_en_r <= hwdata[`SWC_NSRC-1:0];
        end
    end

    // read data registered so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ahb_rd) begin
            unique case (haddr[7:0])
                // mode qualifiers and global enable
                `SWC_CFG_OFF: hrdata <= {24'h00_0000, cfg_r};
                // individual enables
                `SWC_IRQ_EN_OFF: hrdata <= {19'h0_0000, irq_en_r};
                // status and power state
                `SWC_STATUS_OFF: hrdata <= {28'h000_0000,
                    link.wake_req | wdt_wake, state_r == ST_ASLEEP,
                    to_r, pd_r};
                // raw interrupt flags
                `SWC_FLAGS_OFF: hrdata <= {19'h0_0000, irq_flags};
                // unmapped reads as zero
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // zero wait state, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // hsize is ignored; narrower transfers act on the whole word
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8], htrans[0], sleep_nop};
endmodule // sleep_wakeup_control

// ==== test/swc_sva.sv ====
// checker on the controller's top ports
// assumes hclk and async active low hresetn
`timescale 1ns/1ps
module swc_sva
    import swc_pkg::*;
#(
    parameter int PC_W = 21
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // sequencer side
    input wire logic op_valid,
    input wire logic [15:0] opcode,
    input wire logic [PC_W-1:0] pc,
    input wire logic [PC_W-1:0] prefetch_addr,
    input wire logic exec_next,
    input wire logic vector_branch,
    input wire logic core_clk_en,
    // watchdog, pin and power
    input wire logic watchdog_clear,
    input wire logic master_reset_pin_n,
    input wire logic device_reset,
    input wire logic osc_drv_en,
    input wire logic io_hold
);
    // single clock domain
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bad bus answer");
    a_sleep_prefetch: assert property ($fell(core_clk_en) |->
        prefetch_addr == PC_W'($past(pc) + 2))
        else $error("bad prefetch");
    a_sleep_settle: assert property ($fell(core_clk_en) |=>
        (io_hold || exec_next))
        else $error("sleep unsettled");
    a_hold_quiet: assert property (io_hold |->
        !osc_drv_en && !core_clk_en)
        else $error("hold with clock on");
    a_wake_clock: assert property (exec_next |->
        core_clk_en && !$past(core_clk_en))
        else $error("wake without clock");
    a_wake_resume: assert property (exec_next |=>
        osc_drv_en && !io_hold && !device_reset)
        else $error("bad resume");
    a_vector_order: assert property (vector_branch |->
        $past(exec_next))
        else $error("vector too early");
    a_clear_op: assert property (op_valid && opcode == 16'h0004 &&
        core_clk_en |=> watchdog_clear)
        else $error("no watchdog clear");
    a_soft_reset: assert property (op_valid && opcode == 16'h00FF &&
        core_clk_en |-> ##[1:3] device_reset)
        else $error("no soft reset");
    a_pin_reset: assert property ($fell(master_reset_pin_n) |->
        ##[1:4] device_reset)
        else $error("no pin reset");

    // main scenarios seen
    c_asleep: cover property (io_hold);
    c_wake: cover property (exec_next);
    c_vector: cover property (vector_branch);
    c_reset: cover property (device_reset);
endmodule // swc_sva

bind sleep_wakeup_control swc_sva #(.PC_W(PC_W)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .op_valid(op_valid), .opcode(opcode), .pc(pc),
    .prefetch_addr(prefetch_addr), .exec_next(exec_next),
    .vector_branch(vector_branch), .core_clk_en(core_clk_en),
    .watchdog_clear(watchdog_clear),
    .master_reset_pin_n(master_reset_pin_n), .device_reset(device_reset),
    .osc_drv_en(osc_drv_en), .io_hold(io_hold));

// ==== test/periph_model.sv ====
// model of the peripherals, watchdog line and master reset pin
// assumes requests change on rising hclk edges
`timescale 1ns/1ps
module periph_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench requests
    input wire logic [12:0] want_flags,
    input wire logic want_reset,
    input wire logic want_timeout,
    // controller inputs
    output logic [12:0] irq_flags,
    output logic master_reset_pin_n,
    output logic watchdog_timeout
);
    // lines follow requests one edge later; pin idles high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_flags <= 13'h0000;
            master_reset_pin_n <= 1'b1;
            watchdog_timeout <= 1'b0;
        end else begin
            irq_flags <= want_flags;
            master_reset_pin_n <= !want_reset;
            watchdog_timeout <= want_timeout;
        end
    end
endmodule // periph_model

// ==== test/sleep_wakeup_control_test.sv ====
// self-checking bench for the sleep and wake-up controller
// assumes design, checker and model compiled first
`timescale 1ns/1ps
`include "swc_consts.svh"
module sleep_wakeup_control_test;
    import swc_pkg::*;
    localparam int PC_W = 21;
    // bus and sequencer drive
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic op_valid = 1'b0;
    logic [15:0] opcode = 16'h0;
    logic [PC_W-1:0] pc = '0;
    // far side requests
    logic [12:0] want_flags = 13'h0;
    logic want_reset = 1'b0;
    logic want_timeout = 1'b0;
    // design outputs
    logic hready, hreadyout, hresp;
    logic [31:0] hrdata;
    logic [PC_W-1:0] prefetch_addr;
    logic exec_next, vector_branch, core_clk_en, watchdog_clear;
    logic device_reset, osc_drv_en, io_hold;
    logic [12:0] irq_flags;
    logic master_reset_pin_n, watchdog_timeout;
    int err_total = 0;
    int checked = 0;
    logic [31:0] rd;

    always #50 hclk = ~hclk;
    assign hready = hreadyout;

    sleep_wakeup_control #(.PC_W(PC_W)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .op_valid(op_valid), .opcode(opcode), .pc(pc),
        .prefetch_addr(prefetch_addr), .exec_next(exec_next),
        .vector_branch(vector_branch), .core_clk_en(core_clk_en),
        .watchdog_timeout(watchdog_timeout),
        .watchdog_clear(watchdog_clear),
        .master_reset_pin_n(master_reset_pin_n), .irq_flags(irq_flags),
        .device_reset(device_reset), .osc_drv_en(osc_drv_en),
        .io_hold(io_hold));
    periph_model model (.hclk(hclk), .hresetn(hresetn),
        .want_flags(want_flags), .want_reset(want_reset),
        .want_timeout(want_timeout), .irq_flags(irq_flags),
        .master_reset_pin_n(master_reset_pin_n),
        .watchdog_timeout(watchdog_timeout));

    // word and bit comparisons
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask
    // single ahb-lite transfer
    task automatic bus(input logic wr, input logic [7:0] a,
                       inout logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        if (wr) hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        if (!wr) d = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, rd);
        check_word(rd, exp);
    endtask
    // one instruction word, outputs settled on return
    task automatic issue(input logic [15:0] op);
        @(posedge hclk);
        op_valid <= 1'b1;
        opcode <= op;
        @(posedge hclk);
        op_valid <= 1'b0;
        #1;
    endtask
    // bounded waits
    task automatic wait_wake();
        for (int n = 0; n < 40 && exec_next !== 1'b1; n++) @(negedge hclk);
        check_bit(exec_next, 1'b1);
    endtask
    task automatic wait_reset();
        for (int n = 0; n < 20 && device_reset !== 1'b1; n++) @(negedge hclk);
        check_bit(device_reset, 1'b1);
    endtask

    // reset values, read back, unmapped
    task automatic t_reset_values();
        rdchk(`SWC_STATUS_OFF, 32'h3);
        rdchk(`SWC_CFG_OFF, 32'h0);
        rdchk(`SWC_IRQ_EN_OFF, 32'h0);
        rdchk(8'h10, 32'h0);
        wr(`SWC_CFG_OFF, 32'hFF);
        rdchk(`SWC_CFG_OFF, 32'hFF);
        wr(`SWC_CFG_OFF, 32'h0);
        $display("test reset_values done");
    endtask
    // every source: unqualified, qualified, enable off
    task automatic t_qualify();
        int q;
        for (int i = 0; i < 13; i++) begin
            case (i)
                3: q = 2;
                4: q = 3;
                6: q = 4;
                8: q = 5;
                9: q = 6;
                10: q = 7;
                default: q = -1;
            endcase
            for (int c = 0; c < 3; c++) begin
                wr(`SWC_CFG_OFF, (c == 1) ? 32'hFC : 32'h0);
                wr(`SWC_IRQ_EN_OFF, (c == 2) ? 32'h0 : 32'h1 << i);
                want_flags <= 13'h1 << i;
                rdchk(`SWC_FLAGS_OFF, 32'h1 << i);
                bus(1'b0, `SWC_STATUS_OFF, rd);
                check_bit(rd[3], c != 2 && (q < 0 || c == 1));
            end
        end
        want_flags <= 13'h0;
        $display("test qualify done");
    endtask
    // enabled interrupt wakes a sleeping core
    task automatic t_irq_wake(input logic [7:0] cfg);
        wr(`SWC_CFG_OFF, {24'h0, cfg});
        wr(`SWC_IRQ_EN_OFF, 32'h1);
        pc <= 21'h00100;
        issue(`SWC_OP_SLEEP_DEF);
        check_bit(core_clk_en, 1'b0);
        check_bit(watchdog_clear, cfg[0]);
        check_word(32'(prefetch_addr), 32'h102);
        repeat (3) @(negedge hclk);
        check_bit(io_hold, 1'b1);
        check_bit(osc_drv_en, 1'b0);
        rdchk(`SWC_STATUS_OFF, 32'h6);
        want_flags <= 13'h1;
        wait_wake();
        @(negedge hclk);
        check_bit(vector_branch, cfg[1]);
        check_bit(io_hold, 1'b0);
        @(posedge hclk);
        want_flags <= 13'h0;
        $display("test irq_wake done");
    endtask
    // clear op sets both status bits
    task automatic t_clear_op();
        issue(16'h0004);
        check_bit(watchdog_clear, 1'b1);
        rdchk(`SWC_STATUS_OFF, 32'h3);
        $display("test clear_op done");
    endtask
    // pending interrupt makes sleep a nop
    task automatic t_pending_nop();
        wr(`SWC_CFG_OFF, 32'h1);
        want_flags <= 13'h1;
        wr(`SWC_IRQ_EN_OFF, 32'h1);
        issue(`SWC_OP_SLEEP_DEF);
        check_bit(core_clk_en, 1'b1);
        check_bit(watchdog_clear, 1'b0);
        rdchk(`SWC_STATUS_OFF, 32'hB);
        want_flags <= 13'h0;
        $display("test pending_nop done");
    endtask
    // watchdog wake clears timeout bit
    task automatic t_wdog_wake();
        wr(`SWC_IRQ_EN_OFF, 32'h0);
        issue(`SWC_OP_SLEEP_DEF);
        repeat (3) @(posedge hclk);
        want_timeout <= 1'b1;
        wait_wake();
        @(posedge hclk);
        want_timeout <= 1'b0;
        rdchk(`SWC_STATUS_OFF, 32'h0);
        $display("test wdog_wake done");
    endtask
    // software reset clears registers
    task automatic t_soft_reset();
        wr(`SWC_CFG_OFF, 32'hFF);
        wr(`SWC_IRQ_EN_OFF, 32'h1FFF);
        issue(16'h00FF);
        wait_reset();
        rdchk(`SWC_CFG_OFF, 32'h0);
        rdchk(`SWC_IRQ_EN_OFF, 32'h0);
        $display("test soft_reset done");
    endtask
    // pin reset while asleep
    task automatic t_pin_reset();
        wr(`SWC_IRQ_EN_OFF, 32'h1);
        issue(`SWC_OP_SLEEP_DEF);
        repeat (3) @(posedge hclk);
        check_bit(io_hold, 1'b1);
        want_reset <= 1'b1;
        wait_reset();
        repeat (2) @(negedge hclk);
        check_bit(core_clk_en, 1'b1);
        check_bit(io_hold, 1'b0);
        @(posedge hclk);
        want_reset <= 1'b0;
        repeat (5) @(posedge hclk);
        rdchk(`SWC_IRQ_EN_OFF, 32'h0);
        rdchk(`SWC_STATUS_OFF, 32'h2);
        $display("test pin_reset done");
    endtask

    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_qualify();
        t_irq_wake(8'h03);
        t_irq_wake(8'h00);
        t_clear_op();
        t_pending_nop();
        t_wdog_wake();
        t_soft_reset();
        t_pin_reset();
        results();
    end
    // hang guard
    initial begin
        #1000000;
        err_total++;
        results();
    end
endmodule // sleep_wakeup_control_test
